// ### src/bca_pkg.sv
// Package for the leading-zero and ones-count accelerators
`default_nettype none

package bca_pkg;

	// Special function register offsets
	localparam logic [7:0] LZ_CTRL_OFF = 8'h96;
	localparam logic [7:0] LZ_PORT_OFF = 8'h97;
	localparam logic [7:0] OC_CTRL_OFF = 8'h9e;
	localparam logic [7:0] OC_PORT_OFF = 8'h9f;

	// Control register field positions
	localparam int CLR_BIT  = 0;  // Write 1: clear the counter
	localparam int OVF_BIT  = 1;  // Sticky overflow, write 1 clears
	localparam int SEEN_BIT = 2;  // Leading-zero unit: a one was seen
	localparam int COR_BIT  = 3;  // Clear on read of low byte
	localparam int SEL_LSB  = 4;  // Two-bit byte selector, bits 5:4

	// Reset values
	localparam logic [1:0]  SEL_RESET   = 2'h3;
	localparam logic        COR_RESET   = 1'h0;
	localparam logic        OVF_RESET   = 1'h0;
	localparam logic        SEEN_RESET  = 1'h0;
	localparam logic [31:0] COUNT_RESET = 32'h0;
	localparam logic [7:0]  RDATA_RESET = 8'h00;

	// Selector codes
	localparam logic [1:0] SEL_TOP_BYTE = 2'h3;
	localparam logic [1:0] SEL_LOW_BYTE = 2'h0;

	// Documented counter width
	localparam int COUNT_WIDTH = 32;

	// One access from the core on the special function register bus
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bca_sfr_req_type;

	// Read answer back to the core
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} bca_sfr_rsp_type;

endpackage

`default_nettype wire

// ### src/bca_byte_stat.sv
// Byte statistics: ones count and leading zeros of one byte
`timescale 1ns/1ns
`default_nettype none

module bca_byte_stat (
	// Byte in
	input  wire logic [7:0] data,
	// Statistics out
	output logic      [3:0] ones,
	output logic      [3:0] lead,
	output logic            nonzero
);

	// Count the ones of the byte
	always_comb begin
		ones = 4'h0;
		for (int i = 0; i < 8; i++) begin
			ones = ones + {3'h0, data[i]};
		end
	end

	// Zeros from bit 7 downward that come before the first one
	always_comb begin
		logic hit;
		hit  = 1'b0;
		lead = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (data[i]) begin
				hit = 1'b1;
			end else if (!hit) begin
				lead = lead + 4'h1;
			end
		end
	end

	// Any one bit in the byte
	assign nonzero = |data;

endmodule // bca_byte_stat

`default_nettype wire

// ### src/bca_top.sv
// Leading-zero and ones-count accelerators on the core register bus
`timescale 1ns/1ns
`default_nettype none

module bca_top #(
	parameter int COUNT_W = bca_pkg::COUNT_WIDTH
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// Register bus from the core
	input  wire bca_pkg::bca_sfr_req_type sfr_req,
	// Read answer to the core
	output var  bca_pkg::bca_sfr_rsp_type sfr_rsp
);

	// The byte selector reaches four bytes only
	if (COUNT_W != bca_pkg::COUNT_WIDTH) begin : g_width_check
		$error("bca_top: COUNT_W must be 32");
	end

	// Address match against one register offset
	function automatic logic bca_hit(input logic [7:0] addr,
	                                 input logic [7:0] off);
		return addr == off;
	endfunction

	// Unit 0 is the leading-zero unit, unit 1 the ones-count unit
	localparam int NUNITS = 2;

	logic [NUNITS-1:0]  port_wr;
	logic [NUNITS-1:0]  port_rd;
	logic [NUNITS-1:0]  ctrl_wr;
	logic [NUNITS-1:0]  ctrl_rd;
	logic [NUNITS-1:0]  last_rd;
	logic [NUNITS-1:0]  clear;
	logic [NUNITS-1:0]  carry;
	logic [COUNT_W-1:0] count   [NUNITS];
	logic [COUNT_W-1:0] amount  [NUNITS];
	logic [COUNT_W-1:0] next_count [NUNITS];
	logic [1:0]         sel     [NUNITS];
	logic [NUNITS-1:0]  ovf;
	logic [NUNITS-1:0]  cor;
	logic [7:0]         ctrl_val [NUNITS];
	logic [7:0]         port_val [NUNITS];
	logic               seen;
	logic [3:0]         byte_ones;
	logic [3:0]         byte_lead;
	logic               byte_nonzero;

	// Statistics of the byte on the write bus
	bca_byte_stat u_stat (
		.data    (sfr_req.wdata),
		.ones    (byte_ones),
		.lead    (byte_lead),
		.nonzero (byte_nonzero)
	);

	// Register decode
	assign port_wr[0] = sfr_req.wr && bca_hit(sfr_req.addr,
		bca_pkg::LZ_PORT_OFF);
	assign port_wr[1] = sfr_req.wr && bca_hit(sfr_req.addr,
		bca_pkg::OC_PORT_OFF);
	assign port_rd[0] = sfr_req.rd && bca_hit(sfr_req.addr,
		bca_pkg::LZ_PORT_OFF);
	assign port_rd[1] = sfr_req.rd && bca_hit(sfr_req.addr,
		bca_pkg::OC_PORT_OFF);
	assign ctrl_wr[0] = sfr_req.wr && bca_hit(sfr_req.addr,
		bca_pkg::LZ_CTRL_OFF);
	assign ctrl_wr[1] = sfr_req.wr && bca_hit(sfr_req.addr,
		bca_pkg::OC_CTRL_OFF);
	assign ctrl_rd[0] = sfr_req.rd && bca_hit(sfr_req.addr,
		bca_pkg::LZ_CTRL_OFF);
	assign ctrl_rd[1] = sfr_req.rd && bca_hit(sfr_req.addr,
		bca_pkg::OC_CTRL_OFF);

	// Amount added by a port write
	assign amount[0] = seen ? '0 :
		{{(COUNT_W-4){1'b0}}, byte_lead};
	assign amount[1] = {{(COUNT_W-4){1'b0}}, byte_ones};

	// Leading-zero freeze: a one in any written byte ends the zero run
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seen <= bca_pkg::SEEN_RESET;
		end else if (clear[0]) begin
			seen <= bca_pkg::SEEN_RESET;
		end else if (port_wr[0] && byte_nonzero) begin
			seen <= 1'b1;
		end
	end

	for (genvar u = 0; u < NUNITS; u++) begin : g_unit

		// Low byte read and counter clear
		assign last_rd[u] = port_rd[u] && (sel[u] == bca_pkg::SEL_LOW_BYTE);
		assign clear[u] = (ctrl_wr[u] && sfr_req.wdata[bca_pkg::CLR_BIT])
			|| (last_rd[u] && cor[u]);

		// Count plus write amount, with carry out of the top bit
		assign {carry[u], next_count[u]} = {1'b0, count[u]}
			+ {1'b0, amount[u]};

		// Counter: cleared, or updated by a port write
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				count[u] <= bca_pkg::COUNT_RESET;
			end else if (clear[u]) begin
				count[u] <= bca_pkg::COUNT_RESET;
			end else if (port_wr[u]) begin
				count[u] <= next_count[u];
			end
		end

		// Sticky overflow; a carry in a counter clear cycle is ignored, otherwise a carry beats a write-off
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				ovf[u] <= bca_pkg::OVF_RESET;
			end else if (port_wr[u] && !clear[u] && carry[u]) begin
				ovf[u] <= 1'b1;
			end else if (ctrl_wr[u] && sfr_req.wdata[bca_pkg::OVF_BIT]) begin
				ovf[u] <= 1'b0;
			end
		end

		// Byte selector: loaded by control write, steps down on port read
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				sel[u] <= bca_pkg::SEL_RESET;
			end else if (ctrl_wr[u]) begin
				sel[u] <= sfr_req.wdata[bca_pkg::SEL_LSB +: 2];
			end else if (port_rd[u]) begin
				sel[u] <= sel[u] - 2'h1;  // 00b wraps to 11b
			end
		end

		// Clear-on-read enable
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				cor[u] <= bca_pkg::COR_RESET;
			end else if (ctrl_wr[u]) begin
				cor[u] <= sfr_req.wdata[bca_pkg::COR_BIT];
			end
		end

		// Control read image; the clear bit reads as zero
		always_comb begin
			ctrl_val[u] = 8'h00;
			ctrl_val[u][bca_pkg::OVF_BIT] = ovf[u];
			ctrl_val[u][bca_pkg::COR_BIT] = cor[u];
			ctrl_val[u][bca_pkg::SEL_LSB +: 2] = sel[u];
			ctrl_val[u][bca_pkg::SEEN_BIT] = (u == 0) ? seen : 1'b0;
		end

		// Counter byte picked by the selector
		assign port_val[u] = count[u][{sel[u], 3'h0} +: 8];

		// Top byte read at selector 11b
		AST_TOP_BYTE: assert property (
			@(posedge clk) disable iff (rst)
			port_rd[u] && sel[u] == bca_pkg::SEL_TOP_BYTE
			|=> sfr_rsp.valid && sfr_rsp.data == $past(count[u][31:24]))
			else $error("top byte not returned at selector 11b");

		// Selector steps down by one on each port read
		AST_SEL_STEP: assert property (
			@(posedge clk) disable iff (rst)
			port_rd[u] && !ctrl_wr[u] && sel[u] != bca_pkg::SEL_LOW_BYTE
			|=> sel[u] == $past(sel[u]) - 2'h1)
			else $error("selector did not step down");

		// Four reads walk from top byte to low byte then wrap
		AST_FOUR_READS: assert property (
			@(posedge clk) disable iff (rst)
			last_rd[u] && !ctrl_wr[u]
			|=> sel[u] == bca_pkg::SEL_TOP_BYTE
			&& sfr_rsp.data == $past(count[u][7:0]))
			else $error("low byte read did not wrap");

		// Clear on read of the low byte
		AST_CLEAR_ON_READ: assert property (
			@(posedge clk) disable iff (rst)
			last_rd[u] && cor[u] |=> count[u] == '0)
			else $error("clear on read failed");

		// No clear on read when the enable is off
		AST_KEEP_ON_READ: assert property (
			@(posedge clk) disable iff (rst)
			last_rd[u] && !cor[u] && !port_wr[u] && !ctrl_wr[u]
			|=> count[u] == $past(count[u]))
			else $error("count lost without clear on read");

		// A port write adds the byte amount
		AST_ADD: assert property (
			@(posedge clk) disable iff (rst)
			port_wr[u] && !clear[u]
			|=> count[u] == $past(count[u]) + $past(amount[u]))
			else $error("count not advanced by write");

		// Overflow set by a carry and held until written off
		AST_OVF_SET: assert property (
			@(posedge clk) disable iff (rst)
			port_wr[u] && !clear[u] && carry[u]
			|=> ovf[u] [*1] ##1 (ovf[u]
			|| $past(ctrl_wr[u] && sfr_req.wdata[bca_pkg::OVF_BIT])))
			else $error("overflow not held");

		// Control read shows selector and overflow flag
		AST_CTRL_IMAGE: assert property (
			@(posedge clk) disable iff (rst)
			ctrl_rd[u] |=> sfr_rsp.valid
			&& sfr_rsp.data[bca_pkg::SEL_LSB +: 2] == $past(sel[u])
			&& sfr_rsp.data[bca_pkg::OVF_BIT] == $past(ovf[u]))
			else $error("control image wrong");

		// Control write with the clear bit empties the counter
		AST_CLR_BIT: assert property (
			@(posedge clk) disable iff (rst)
			ctrl_wr[u] && sfr_req.wdata[bca_pkg::CLR_BIT]
			|=> count[u] == bca_pkg::COUNT_RESET)
			else $error("clear bit left the count");

		// Control write loads the byte selector
		AST_SEL_LOAD: assert property (
			@(posedge clk) disable iff (rst)
			ctrl_wr[u]
			|=> sel[u] == $past(sfr_req.wdata[bca_pkg::SEL_LSB +: 2]))
			else $error("selector not loaded by control write");

		// Selector holds without a port read or control write
		AST_SEL_HOLD: assert property (
			@(posedge clk) disable iff (rst)
			!port_rd[u] && !ctrl_wr[u] |=> sel[u] == $past(sel[u]))
			else $error("selector moved without an access");

		// Count holds without a port write or clear
		AST_COUNT_HOLD: assert property (
			@(posedge clk) disable iff (rst)
			!port_wr[u] && !clear[u] |=> count[u] == $past(count[u]))
			else $error("count moved without a write");

		// Overflow written off with bit 1, unless a carry sets it
		AST_OVF_CLEAR: assert property (
			@(posedge clk) disable iff (rst)
			ctrl_wr[u] && sfr_req.wdata[bca_pkg::OVF_BIT]
			&& !(port_wr[u] && carry[u]) |=> !ovf[u])
			else $error("overflow not written off");

		// Overflow stays set until written off
		AST_OVF_HOLD: assert property (
			@(posedge clk) disable iff (rst)
			ovf[u] && !(ctrl_wr[u] && sfr_req.wdata[bca_pkg::OVF_BIT])
			|=> ovf[u])
			else $error("overflow dropped by itself");

	end

	// Read answer, registered one cycle after the read strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sfr_rsp.valid <= 1'b0;
			sfr_rsp.data  <= bca_pkg::RDATA_RESET;
		end else begin
			sfr_rsp.valid <= |{port_rd, ctrl_rd};
			if (port_rd[0]) begin
				sfr_rsp.data <= port_val[0];
			end else if (port_rd[1]) begin
				sfr_rsp.data <= port_val[1];
			end else if (ctrl_rd[0]) begin
				sfr_rsp.data <= ctrl_val[0];
			end else if (ctrl_rd[1]) begin
				sfr_rsp.data <= ctrl_val[1];
			end else begin
				sfr_rsp.data <= bca_pkg::RDATA_RESET;
			end
		end
	end

	// Frozen leading-zero count ignores further writes
	AST_LZ_FREEZE: assert property (
		@(posedge clk) disable iff (rst)
		seen && port_wr[0] && !clear[0] |=> count[0] == $past(count[0]))
		else $error("leading zero count moved after a one");

	// Leading zeros counted from bit 7 down
	AST_LZ_ORDER: assert property (
		@(posedge clk) disable iff (rst)
		!seen && port_wr[0] && !clear[0] && sfr_req.wdata[7]
		|=> count[0] == $past(count[0]) && seen)
		else $error("msb one still counted as zero");

	// Ones count keeps counting after zeros
	AST_OC_NO_HALT: assert property (
		@(posedge clk) disable iff (rst)
		port_wr[1] && !clear[1] && sfr_req.wdata == 8'hff
		|=> count[1] == $past(count[1]) + 32'h8)
		else $error("ones count did not add eight");

	// No read strobe, no answer: valid low and data at rest
	AST_RSP_IDLE: assert property (
		@(posedge clk) disable iff (rst)
		!(|{port_rd, ctrl_rd})
		|=> !sfr_rsp.valid && sfr_rsp.data == bca_pkg::RDATA_RESET)
		else $error("answer given without a read");

	// Ones count advances by the ones of the written byte
	AST_OC_COUNT: assert property (
		@(posedge clk) disable iff (rst)
		port_wr[1] && !clear[1]
		|=> count[1] == $past(count[1]) + $countones($past(sfr_req.wdata)))
		else $error("ones count off by the byte");

	// A zero byte before any one adds eight and keeps counting
	AST_LZ_ZERO_BYTE: assert property (
		@(posedge clk) disable iff (rst)
		!seen && port_wr[0] && !clear[0] && sfr_req.wdata == 8'h00
		|=> count[0] == $past(count[0]) + 32'h8 && !seen)
		else $error("zero byte not counted as eight");

	// Any clear of the leading-zero unit forgets the one seen
	AST_SEEN_CLEAR: assert property (
		@(posedge clk) disable iff (rst)
		clear[0] |=> !seen)
		else $error("one seen survived a clear");

endmodule // bca_top

`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the bit count accelerators
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	// Register offsets and one unmapped address
	localparam logic [7:0] zc = bca_pkg::LZ_CTRL_OFF;
	localparam logic [7:0] zp = bca_pkg::LZ_PORT_OFF;
	localparam logic [7:0] oc = bca_pkg::OC_CTRL_OFF;
	localparam logic [7:0] op = bca_pkg::OC_PORT_OFF;
	localparam logic [7:0] nm = 8'h55;

	// One bus cycle beside the answer it should give
	typedef struct packed {
		bca_pkg::bca_sfr_req_type q;
		bca_pkg::bca_sfr_rsp_type p;
	} bca_row_type;

	logic                     clk = 1'b0;
	logic                     rst = 1'b1;
	bca_pkg::bca_sfr_req_type req = '0;
	bca_pkg::bca_sfr_rsp_type rsp;
	bca_row_type              rows[$];
	int                       fails = 0;
	int                       checked = 0;
	int                       cyc = 0;

	// Device under test
	bca_top i_bca_top (
		.clk     (clk),
		.rst     (rst),
		.sfr_req (req),
		.sfr_rsp (rsp)
	);

	// Clock of 100 ns period
	always #50 clk = ~clk;

	// Hang guard, the run needs about 55 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 500) begin
			fails = fails + 1;
			close_out();
		end
	end

	// Compare seen against expected
	task automatic cmp(input logic [8:0] seen, input logic [8:0] exp,
			input string msg);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t ns: %s got %h want %h",
				$time, msg, seen, exp);
		end
	endtask

	// Counts and verdict
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Queue a write, which gives no answer
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		rows.push_back({1'b1, 1'b0, a, d, 1'b0, 8'h00});
	endtask

	// Queue a read with its expected byte
	task automatic r(input logic [7:0] a, input logic [7:0] x);
		rows.push_back({1'b0, 1'b1, a, 8'h00, 1'b1, x});
	endtask

	// Single access, answer checked one cycle later
	task automatic acc(input logic [17:0] q, input logic [8:0] x,
			input string m);
		@(posedge clk);
		req <= q;
		@(posedge clk);
		req <= '0;
		#1;
		cmp(rsp, x, m);
	endtask

	// Main sequence
	initial begin
		w(op, 8'hf0);
		w(op, 8'h00);
		w(op, 8'hff);
		r(op, 8'h00);
		r(op, 8'h00);
		r(op, 8'h00);
		r(op, 8'h0c);
		r(op, 8'h00);
		w(zp, 8'h00);
		w(zp, 8'h10);
		w(zp, 8'h00);
		r(zc, 8'h34);
		w(zc, 8'h38);
		r(zc, 8'h3c);
		r(zp, 8'h00);
		r(zp, 8'h00);
		r(zp, 8'h00);
		r(zp, 8'h0b);
		w(zc, 8'h30);
		w(zp, 8'h01);
		r(zc, 8'h34);
		r(zp, 8'h00);
		r(zp, 8'h00);
		r(zp, 8'h00);
		r(zp, 8'h07);
		w(zc, 8'h03);
		r(zc, 8'h00);
		w(zp, 8'h80);
		r(zp, 8'h00);
		r(zc, 8'h34);
		w(oc, 8'h08);
		r(op, 8'h0c);
		r(oc, 8'h38);
		w(oc, 8'h00);
		r(op, 8'h00);
		w(nm, 8'hff);
		rows.push_back({2'b01, nm, 8'h00, 9'h000});
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// Rows back to back, answer checked the cycle after
		for (int i = 0; i <= rows.size(); i++) begin
			@(posedge clk);
			if (i < rows.size())
				req <= rows[i].q;
			else
				req <= '0;
			#1;
			if (i > 0)
				cmp(rsp, rows[i-1].p, $sformatf("row %0d", i - 1));
		end
		$display("Table test done");
		// Reset landing on a pending answer
		acc({2'b10, op, 8'hff}, 9'h000, "write before reset");
		@(posedge clk);
		req <= {2'b01, op, 8'h00};
		@(posedge clk);
		req <= '0;
		rst <= 1'b1;
		#1;
		cmp(rsp, 9'h000, "answer under reset");
		@(posedge clk);
		rst <= 1'b0;
		acc({2'b01, oc, 8'h00}, 9'h130, "ones control reset");
		acc({2'b01, zc, 8'h00}, 9'h130, "zero control reset");
		acc({2'b10, oc, 8'h00}, 9'h000, "select low byte");
		acc({2'b01, op, 8'h00}, 9'h100, "count after reset");
		$display("Reset test done");
		close_out();
	end
endmodule // tb_top

`default_nettype wire
